// *** verilog/ttd_pkg.sv ***
// Package: constants and state layout of the trap, trigger and debug CSR bank
`default_nettype none

package ttd_pkg;

    // CSR addresses
    localparam logic [11:0] ADDR_TRAP_CAUSE = 12'h342;
    localparam logic [11:0] ADDR_TRAP_VALUE = 12'h343;
    localparam logic [11:0] ADDR_IRQ_PENDING = 12'h344;
    localparam logic [11:0] ADDR_TRIG_SELECT = 12'h7A0;
    localparam logic [11:0] ADDR_TRIG_MATCH_CONTROL = 12'h7A1;
    localparam logic [11:0] ADDR_TRIG_MATCH_ADDRESS = 12'h7A2;
    localparam logic [11:0] ADDR_TRIG_AUX_DATA = 12'h7A3;
    localparam logic [11:0] ADDR_TRIG_TYPE_INFO = 12'h7A4;
    localparam logic [11:0] ADDR_MACHINE_CONTEXT = 12'h7A8;
    localparam logic [11:0] ADDR_DEBUG_CONTROL = 12'h7B0;

    // Field positions
    localparam int CAUSE_IRQ_BIT = 31;
    localparam int TMC_EXEC_BIT = 2;
    localparam int DCSR_EBREAKM_BIT = 15;
    localparam int DCSR_STEPIE_BIT = 11;
    localparam int DCSR_STEP_BIT = 2;
    localparam int DCSR_CAUSE_LSB = 6;

    // Reset and fixed values
    localparam logic [31:0] TMC_RESET = 32'h2800_1040;
    localparam logic [31:0] DCSR_RESET = 32'h4000_0003;
    localparam logic [31:0] IRQ_PENDING_MASK = 32'hFFFF_0888;
    localparam logic [15:0] TINFO_SUPPORTED = 16'h0004;
    localparam logic [15:0] TINFO_NO_TRIGGER = 16'h0001;
    localparam logic [31:0] TRIG_SELECT_VALUE = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [2:0] DBG_CAUSE_RESET = 3'h0;
    localparam logic [2:0] DBG_CAUSE_TRIGGER = 3'h2;

    // CSR access request
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ttd_csr_req_s;

    // Trap report from the core
    typedef struct packed {
        logic take;
        logic is_irq;
        logic [4:0] code;
    } ttd_trap_s;

    // Whole state of the bank
    typedef struct packed {
        logic cause_irq;
        logic [4:0] cause_code;
        logic [31:0] irq_meta;
        logic [31:0] irq_sync;
        logic tm_exec;
        logic [31:0] tm_addr;
        logic dbg_ebreakm;
        logic dbg_stepie;
        logic dbg_step;
        logic [2:0] dbg_cause;
        logic [31:0] rdata;
        logic rvalid;
        logic err;
        logic hit;
    } ttd_state_s;

endpackage

`default_nettype wire

// *** verilog/ttd_csr.sv ***
// Module: trap cause, interrupt pending, trigger and debug control CSR bank
`timescale 1ns/1ps
`default_nettype none

module ttd_csr
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire ttd_pkg::ttd_csr_req_s csr_req_i,
    input wire logic debug_mode_i,
    input wire logic machine_mode_i,
    input wire ttd_pkg::ttd_trap_s trap_i,
    input wire logic [31:0] irq_i,
    input wire logic fetch_valid_i,
    input wire logic [31:0] fetch_addr_i,
    input wire logic debug_enter_i,
    input wire logic [2:0] debug_cause_i,
    output logic [31:0] csr_rdata_o,
    output logic csr_rvalid_o,
    output logic csr_err_o,
    output logic trigger_hit_o,
    output logic [31:0] irq_pending_o,
    output logic ebreakm_o,
    output logic stepie_o,
    output logic step_o
);
    import ttd_pkg::*;

    ttd_state_s st;
    ttd_state_s next_st;

    // Info field depends on whether the selected trigger exists
    function automatic logic [31:0] type_info(input logic [31:0] sel);
        logic [31:0] v;
        v = ZERO_WORD;
        if (sel == TRIG_SELECT_VALUE)
        begin
            v[15:0] = TINFO_SUPPORTED;
        end
        else
        begin
            v[15:0] = TINFO_NO_TRIGGER;
        end
        return v;
    endfunction

    function automatic logic is_trigger_addr(input logic [11:0] a);
        return (a == ADDR_TRIG_SELECT) || (a == ADDR_TRIG_MATCH_CONTROL)
            || (a == ADDR_TRIG_MATCH_ADDRESS) || (a == ADDR_TRIG_AUX_DATA)
            || (a == ADDR_TRIG_TYPE_INFO) || (a == ADDR_MACHINE_CONTEXT);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return is_trigger_addr(a) || (a == ADDR_TRAP_CAUSE) || (a == ADDR_TRAP_VALUE)
            || (a == ADDR_IRQ_PENDING) || (a == ADDR_DEBUG_CONTROL);
    endfunction

    logic [31:0] cause_word;
    logic [31:0] tmc_word;
    logic [31:0] dcsr_word;
    logic [31:0] pend_word;
    logic [31:0] read_word;
    logic access_ok;

    always_comb
    begin
        cause_word = ZERO_WORD;
        cause_word[CAUSE_IRQ_BIT] = st.cause_irq;
        cause_word[4:0] = st.cause_code;

        // Fixed fields come from the reset pattern; only execute varies
        tmc_word = TMC_RESET;
        tmc_word[TMC_EXEC_BIT] = st.tm_exec;

        // Hardwired fields, including prv and version, come from the reset pattern
        dcsr_word = DCSR_RESET;
        dcsr_word[DCSR_EBREAKM_BIT] = st.dbg_ebreakm;
        dcsr_word[DCSR_STEPIE_BIT] = st.dbg_stepie;
        dcsr_word[DCSR_STEP_BIT] = st.dbg_step;
        dcsr_word[DCSR_CAUSE_LSB +: 3] = st.dbg_cause;

        pend_word = st.irq_sync & IRQ_PENDING_MASK;

        // Trigger space is closed outside debug and machine mode
        access_ok = is_mapped(csr_req_i.addr)
            && (!is_trigger_addr(csr_req_i.addr) || debug_mode_i || machine_mode_i);

        case (csr_req_i.addr)
            ADDR_TRAP_CAUSE: read_word = cause_word;
            ADDR_TRAP_VALUE: read_word = ZERO_WORD;
            ADDR_IRQ_PENDING: read_word = pend_word;
            ADDR_TRIG_SELECT: read_word = TRIG_SELECT_VALUE;
            ADDR_TRIG_MATCH_CONTROL: read_word = tmc_word;
            ADDR_TRIG_MATCH_ADDRESS: read_word = st.tm_addr;
            ADDR_TRIG_AUX_DATA: read_word = ZERO_WORD;
            ADDR_TRIG_TYPE_INFO: read_word = type_info(TRIG_SELECT_VALUE);
            ADDR_MACHINE_CONTEXT: read_word = ZERO_WORD;
            ADDR_DEBUG_CONTROL: read_word = dcsr_word;
            default: read_word = ZERO_WORD;
        endcase
    end

    always_comb
    begin
        next_st = st;

        // Two-stage synchroniser on the asynchronous request lines
        next_st.irq_meta = irq_i;
        // Mask between the stages so the output flop holds only live bits
        next_st.irq_sync = st.irq_meta & IRQ_PENDING_MASK;

        next_st.rvalid = csr_req_i.valid;
        next_st.err = csr_req_i.valid && !access_ok;
        next_st.rdata = (csr_req_i.valid && access_ok) ? read_word : ZERO_WORD;

        if (csr_req_i.valid && csr_req_i.write && access_ok)
        begin
            case (csr_req_i.addr)
                ADDR_TRAP_CAUSE:
                begin
                    next_st.cause_irq = csr_req_i.wdata[CAUSE_IRQ_BIT];
                    next_st.cause_code = csr_req_i.wdata[4:0];
                end
                ADDR_TRIG_MATCH_CONTROL:
                begin
                    if (debug_mode_i)
                    begin
                        next_st.tm_exec = csr_req_i.wdata[TMC_EXEC_BIT];
                    end
                end
                ADDR_TRIG_MATCH_ADDRESS:
                begin
                    if (debug_mode_i)
                    begin
                        next_st.tm_addr = csr_req_i.wdata;
                    end
                end
                ADDR_DEBUG_CONTROL:
                begin
                    next_st.dbg_ebreakm = csr_req_i.wdata[DCSR_EBREAKM_BIT];
                    next_st.dbg_stepie = csr_req_i.wdata[DCSR_STEPIE_BIT];
                    next_st.dbg_step = csr_req_i.wdata[DCSR_STEP_BIT];
                end
                default:
                begin
                    next_st.cause_code = st.cause_code;
                end
            endcase
        end

        // A trap in the same cycle as a software write wins
        if (trap_i.take)
        begin
            next_st.cause_irq = trap_i.is_irq;
            next_st.cause_code = trap_i.code;
        end

        if (debug_enter_i)
        begin
            next_st.dbg_cause = debug_cause_i;
        end

        // Hit is raised from the fetch stage so entry precedes execution
        next_st.hit = st.tm_exec && fetch_valid_i && !debug_mode_i
            && (fetch_addr_i == st.tm_addr);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.dbg_cause <= DBG_CAUSE_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign csr_rdata_o = st.rdata;
    assign csr_rvalid_o = st.rvalid;
    assign csr_err_o = st.err;
    assign trigger_hit_o = st.hit;
    assign irq_pending_o = st.irq_sync;
    assign ebreakm_o = st.dbg_ebreakm;
    assign stepie_o = st.dbg_stepie;
    assign step_o = st.dbg_step;

    a_cause_irq_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
        trap_i.take |=> (st.cause_irq == $past(trap_i.is_irq)))
        else $error("cause interrupt bit does not follow trap kind");

    a_cause_code_upd: assert property (@(posedge core_clk_i) disable iff (rst_i)
        trap_i.take |=> st.cause_code == $past(trap_i.code))
        else $error("cause code not captured from trap");

    a_cause_zero_mid: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_rvalid_o && !csr_err_o && $past(csr_req_i.addr) == ADDR_TRAP_CAUSE)
            |-> csr_rdata_o[30:5] == 26'h0)
        else $error("cause reserved bits not zero");

    a_trap_value_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.addr == ADDR_TRAP_VALUE) |=> csr_rdata_o == ZERO_WORD)
        else $error("trap value read not zero");

    a_pending_mask: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (irq_pending_o & ~IRQ_PENDING_MASK) == ZERO_WORD)
        else $error("pending shows hardwired bit");

    a_pending_sync: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ##2 irq_pending_o[31:16] == $past(irq_i[31:16], 2))
        else $error("fast pending does not follow request line");

    a_tmc_locked: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.write && !debug_mode_i
            && (csr_req_i.addr == ADDR_TRIG_MATCH_CONTROL
                || csr_req_i.addr == ADDR_TRIG_MATCH_ADDRESS))
            |=> $stable(st.tm_exec) && $stable(st.tm_addr))
        else $error("match control changed outside debug mode");

    a_trigger_denied: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && !debug_mode_i && !machine_mode_i
            && is_trigger_addr(csr_req_i.addr)) |=> csr_err_o && csr_rdata_o == ZERO_WORD)
        else $error("trigger access allowed outside permitted modes");

    a_trigger_hit: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.tm_exec && fetch_valid_i && !debug_mode_i && fetch_addr_i == st.tm_addr)
            |=> trigger_hit_o)
        else $error("address match did not raise hit");

    a_dcsr_fixed: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && machine_mode_i && csr_req_i.addr == ADDR_DEBUG_CONTROL)
            |=> csr_rdata_o[1:0] == 2'h3 && csr_rdata_o[31:28] == 4'h4
                && csr_rdata_o[13:12] == 2'h0)
        else $error("debug control fixed fields wrong");

    a_tinfo_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && debug_mode_i && csr_req_i.addr == ADDR_TRIG_TYPE_INFO)
            |=> csr_rdata_o == 32'h0000_0004)
        else $error("type info not 0x4");

    a_tmc_pattern: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && debug_mode_i && csr_req_i.addr == ADDR_TRIG_MATCH_CONTROL)
            |=> (csr_rdata_o & 32'hFFFF_FFFB) == 32'h2800_1040)
        else $error("match control fixed fields wrong");

    // Storage checks compare against the request one cycle earlier
    a_cause_sw_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.write && csr_req_i.addr == ADDR_TRAP_CAUSE
            && !trap_i.take)
            |=> st.cause_irq == $past(csr_req_i.wdata[CAUSE_IRQ_BIT])
                && st.cause_code == $past(csr_req_i.wdata[4:0]))
        else $error("cause software write not stored");

    a_trap_beats_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (trap_i.take && csr_req_i.valid && csr_req_i.write
            && csr_req_i.addr == ADDR_TRAP_CAUSE)
            |=> st.cause_irq == $past(trap_i.is_irq) && st.cause_code == $past(trap_i.code))
        else $error("software write overrode a trap");

    a_select_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.addr == ADDR_TRIG_SELECT) |=> csr_rdata_o == ZERO_WORD)
        else $error("trigger select not zero");

    a_aux_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && (csr_req_i.addr == ADDR_TRIG_AUX_DATA
            || csr_req_i.addr == ADDR_MACHINE_CONTEXT)) |=> csr_rdata_o == ZERO_WORD)
        else $error("aux data or context not zero");

    a_tm_exec_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.write && debug_mode_i
            && csr_req_i.addr == ADDR_TRIG_MATCH_CONTROL)
            |=> st.tm_exec == $past(csr_req_i.wdata[TMC_EXEC_BIT]))
        else $error("execute enable not written");

    a_tm_addr_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.write && debug_mode_i
            && csr_req_i.addr == ADDR_TRIG_MATCH_ADDRESS)
            |=> st.tm_addr == $past(csr_req_i.wdata))
        else $error("match address not written");

    a_dcsr_bits_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.write && csr_req_i.addr == ADDR_DEBUG_CONTROL)
            |=> ebreakm_o == $past(csr_req_i.wdata[DCSR_EBREAKM_BIT])
                && stepie_o == $past(csr_req_i.wdata[DCSR_STEPIE_BIT])
                && step_o == $past(csr_req_i.wdata[DCSR_STEP_BIT]))
        else $error("debug control storage bits not written");

    a_dcsr_hardwired: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.addr == ADDR_DEBUG_CONTROL)
            |=> (csr_rdata_o & 32'h0FFF_763B) == 32'h0000_0003)
        else $error("debug control hardwired bits wrong");

    a_dcsr_version: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.addr == ADDR_DEBUG_CONTROL)
            |=> csr_rdata_o[31:28] == 4'h4)
        else $error("debug version field not 4");

    a_dbg_cause_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
        debug_enter_i |=> st.dbg_cause == $past(debug_cause_i))
        else $error("debug cause not captured on entry");

    a_dbg_cause_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !debug_enter_i |=> $stable(st.dbg_cause))
        else $error("debug cause changed without entry");

    a_pending_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && csr_req_i.addr == ADDR_IRQ_PENDING)
            |=> csr_rdata_o == $past(irq_pending_o))
        else $error("pending read differs from pending output");

    a_trigger_allowed: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && (debug_mode_i || machine_mode_i)
            && is_trigger_addr(csr_req_i.addr)) |=> csr_rvalid_o && !csr_err_o)
        else $error("trigger access refused in a permitted mode");

    a_unmapped_err: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && !is_mapped(csr_req_i.addr))
            |=> csr_err_o && csr_rdata_o == ZERO_WORD)
        else $error("unmapped access not refused");

    a_idle_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !csr_req_i.valid |=> !csr_rvalid_o && !csr_err_o)
        else $error("answer without a request");

    a_tmc_machine_view: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (csr_req_i.valid && machine_mode_i && csr_req_i.addr == ADDR_TRIG_MATCH_CONTROL)
            |=> csr_rdata_o[31:27] == 5'h05 && csr_rdata_o[15:12] == 4'h1
                && csr_rdata_o[6] == 1'b1 && csr_rdata_o[18] == 1'b0)
        else $error("match control fixed fields wrong in machine mode");

    // A hit needs an enabled, exact, non-debug fetch
    a_hit_debug_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (debug_mode_i || !fetch_valid_i) |=> !trigger_hit_o)
        else $error("hit raised in debug mode or without fetch");

    a_hit_exact: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (fetch_addr_i != st.tm_addr) |=> !trigger_hit_o)
        else $error("hit on a non-matching address");

    a_hit_needs_exec: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !st.tm_exec |=> !trigger_hit_o)
        else $error("hit raised with execute disabled");

endmodule // ttd_csr

`default_nettype wire

// *** testbench/ttd_partner.sv ***
// Partner model: interrupt sources and debug module answering hits
`timescale 1ns/1ps
`default_nettype none
module ttd_partner
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [31:0] irq_level_i,
    input wire logic trigger_hit_i,
    output logic [31:0] irq_o,
    output logic debug_enter_o,
    output logic [2:0] debug_cause_o
);
    import ttd_pkg::*;
    assign irq_o = irq_level_i;
    // Debug entry follows a hit by one cycle, before the instruction runs
    always_ff @(posedge core_clk_i)
    begin
        debug_enter_o <= !rst_i && trigger_hit_i;
    end
    // Cause lines carry junk when not entering, so a stray capture shows
    assign debug_cause_o = debug_enter_o ? DBG_CAUSE_TRIGGER : ~DBG_CAUSE_TRIGGER;
endmodule // ttd_partner
`default_nettype wire

// *** testbench/tb.sv ***
// Testbench: CSR traffic, traps, interrupts and trigger for the CSR bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ttd_pkg::*;
    logic core_clk_i, rst_i, dbg, mach, fvalid, denter, rvalid, err, hit, ebm, sie, stp;
    ttd_csr_req_s req;
    ttd_trap_s trap;
    logic [31:0] irq_level, irq, faddr, rdata, pend, rnd, d, dcsr_w;
    logic [2:0] dcause;
    int err_total, comparisons;
    logic [11:0] adr [10] = '{12'h342, 12'h343, 12'h344, 12'h7A0, 12'h7A1,
        12'h7A2, 12'h7A3, 12'h7A4, 12'h7A8, 12'h7B0};
    logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2800_1040,
        32'h0, 32'h0, 32'h0000_0004, 32'h0, 32'h4000_0003};
    ttd_csr dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .csr_req_i(req),
        .debug_mode_i(dbg), .machine_mode_i(mach), .trap_i(trap), .irq_i(irq),
        .fetch_valid_i(fvalid), .fetch_addr_i(faddr), .debug_enter_i(denter),
        .debug_cause_i(dcause), .csr_rdata_o(rdata), .csr_rvalid_o(rvalid),
        .csr_err_o(err), .trigger_hit_o(hit), .irq_pending_o(pend),
        .ebreakm_o(ebm), .stepie_o(sie), .step_o(stp));
    ttd_partner far (.core_clk_i(core_clk_i), .rst_i(rst_i), .irq_level_i(irq_level),
        .trigger_hit_i(hit), .irq_o(irq), .debug_enter_o(denter), .debug_cause_o(dcause));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Read-back value after a debug-mode write, reset state otherwise
    function automatic logic [31:0] exp_wr(input logic [11:0] a, input logic [31:0] v);
        case (a)
            12'h7A1: return 32'h2800_1040 | (v & 32'h0000_0004);
            12'h7A2: return v;
            12'h7A4: return 32'h0000_0004;
            12'h7B0: return 32'h4000_0003 | (v & 32'h0000_8804);
            default: return 32'h0000_0000;
        endcase
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    // Request held one cycle; answer checked in the following cycle
    task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] v,
        input logic [31:0] want, input logic want_err);
        req = '{1'b1, w, a, v};
        @(posedge core_clk_i);
        #1;
        check({31'h0, rvalid}, 32'h1);
        check({31'h0, err}, {31'h0, want_err});
        if (!w)
            check(rdata, want);
    endtask
    task automatic quiet(input int n);
        req.valid = 1'b0;
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        #20000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        rst_i = 1'b1;
        {dbg, fvalid, faddr, irq_level, dcsr_w, err_total, comparisons} = '0;
        mach = 1'b1;
        req = '0;
        trap = '0;
        rnd = 32'h0000_D6C4;
        repeat (5) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        for (int i = 0; i < 10; i++)
            csr(1'b0, adr[i], 32'h0, rv[i], 1'b0);
        $display("test reset values done");
        csr(1'b1, 12'h343, 32'hFFFF_FFFF, 32'h0, 1'b0);
        csr(1'b0, 12'h343, 32'h0, 32'h0, 1'b0);
        csr(1'b0, 12'h7A5, 32'h0, 32'h0, 1'b1);
        csr(1'b1, 12'h7A1, 32'hFFFF_FFFF, 32'h0, 1'b0);
        csr(1'b1, 12'h7A2, 32'h1234_5678, 32'h0, 1'b0);
        csr(1'b0, 12'h7A1, 32'h0, 32'h2800_1040, 1'b0);
        csr(1'b0, 12'h7A2, 32'h0, 32'h0, 1'b0);
        quiet(1);
        mach = 1'b0;
        csr(1'b0, 12'h7A2, 32'h0, 32'h0, 1'b1);
        quiet(1);
        $display("test refusals done");
        {dbg, mach} = 2'b11;
        for (int k = 0; k < 4; k++)
            for (int i = 3; i < 10; i++)
            begin
                rnd = xs(rnd);
                d = (k == 0) ? 32'hFFFF_FFFF : rnd;
                if (adr[i] == 12'h7B0)
                    dcsr_w = d & 32'h0000_8804;
                csr(1'b1, adr[i], d, 32'h0, 1'b0);
                csr(1'b0, adr[i], 32'h0, exp_wr(adr[i], d), 1'b0);
                check({29'h0, ebm, sie, stp}, {29'h0, dcsr_w[15], dcsr_w[11], dcsr_w[2]});
            end
        $display("test debug writes done");
        csr(1'b1, 12'h342, 32'h7FFF_FFE3, 32'h0, 1'b0);
        csr(1'b0, 12'h342, 32'h0, 32'h0000_0003, 1'b0);
        csr(1'b1, 12'h342, 32'h8000_0007, 32'h0, 1'b0);
        csr(1'b0, 12'h342, 32'h0, 32'h8000_0007, 1'b0);
        quiet(1);
        for (int i = 0; i < 4; i++)
        begin
            trap = '{1'b1, i[0], (i < 2) ? 5'd11 : 5'd16 + 5'(i)};
            csr(1'b1, 12'h342, 32'h0000_0002, 32'h0, 1'b0);
            trap.take = 1'b0;
            csr(1'b0, 12'h342, 32'h0, {i[0], 26'h0, trap.code}, 1'b0);
            quiet(1);
        end
        $display("test traps done");
        for (int i = 0; i < 5; i++)
        begin
            rnd = xs(rnd);
            irq_level = (i == 0) ? 32'hFFFF_FFFF : rnd;
            quiet(4);
            check(pend, irq_level & 32'hFFFF_0888);
            csr(1'b0, 12'h344, 32'h0, irq_level & 32'hFFFF_0888, 1'b0);
        end
        quiet(1);
        $display("test interrupt pending done");
        csr(1'b1, 12'h7A1, 32'h0000_0004, 32'h0, 1'b0);
        csr(1'b1, 12'h7A2, rnd, 32'h0, 1'b0);
        quiet(1);
        dbg = 1'b0;
        fvalid = 1'b1;
        faddr = rnd ^ 32'h0000_0004;
        @(posedge core_clk_i);
        #1 check({31'h0, hit}, 32'h0);
        faddr = rnd;
        @(posedge core_clk_i);
        #1 check({31'h0, hit}, 32'h1);
        fvalid = 1'b0;
        @(posedge core_clk_i);
        #1 check({31'h0, hit}, 32'h0);
        quiet(2);
        csr(1'b0, 12'h7B0, 32'h0, 32'h4000_0083 | dcsr_w, 1'b0);
        quiet(1);
        $display("test trigger hit done");
        give_verdict();
    end
endmodule // tb
`default_nettype wire
